/* File: core/scrp_pkg.sv */
// package for the sdram command, refresh and power-down control block
package scrp_pkg;
  localparam logic [3:0]  ADDR_CMD        = 4'h4;
  localparam logic [3:0]  ADDR_RFSH       = 4'h8;
  localparam logic [3:0]  ADDR_APD        = 4'hc;
  localparam int          P_STAT_BIT      = 26;
  localparam int          P_ON_BIT        = 25;
  localparam int          P_OFF_BIT       = 24;
  localparam int          P_LAUNCH_BIT    = 20;
  localparam int          P_CODE_LSB      = 16;
  localparam int          S_STAT_BIT      = 10;
  localparam int          S_ON_BIT        = 9;
  localparam int          S_OFF_BIT       = 8;
  localparam int          S_LAUNCH_BIT    = 4;
  localparam int          S_CODE_LSB      = 0;
  localparam int          APD_GATE_BIT    = 4;
  localparam int          APD_MODE_LSB    = 2;
  localparam int          APD_TIMER_LSB   = 0;
  localparam logic [15:0] RFSH_RESET      = 16'h0000;
  localparam logic [4:0]  APD_RESET       = 5'h00;
  localparam logic [3:0]  RFC_SPACING     = 4'h9;   // minimum refresh spacing code, 10 clocks
  localparam logic [9:0]  IDLE_BASE       = 10'h040; // 64 cycles, doubled per timer step
  localparam logic [3:0]  CMD_TIME        = 4'h4;   // one-shot command time code, ST_CMD lasts 5 clocks
  localparam logic [3:0]  ACC_TIME        = 4'h6;   // access time code, access_busy lasts 7 clocks
  localparam logic [3:0]  OP_NORMAL       = 4'h0;
  localparam logic [3:0]  OP_WIPE         = 4'h7;
  typedef enum logic [1:0] {APD_OFF, APD_PRECHARGE, APD_ACTIVE, APD_SELFREF} scrp_apd_type;
  typedef enum {ST_IDLE, ST_ACCESS, ST_CMD, ST_REFRESH, ST_SLEEP, ST_WAKE} scrp_state_type;
endpackage

/* File: core/scrp_ctrl.sv */
// sdram command, refresh and power-down control
`timescale 1ns/1ps
module scrp_ctrl
  import scrp_pkg::*;
(
  input  wire logic        sys_clk,        // system clock, 125 MHz
  input  wire logic        nrst,           // synchronous reset, active low
  input  wire logic [3:0]  reg_addr,       // register byte address
  input  wire logic [31:0] reg_wdata,      // register write data
  input  wire logic        reg_wr,         // write strobe
  input  wire logic        reg_rd,         // read strobe
  output logic      [31:0] reg_rdata,      // read data, cycle after strobe
  input  wire logic        access_req,     // memory access request, same domain
  output logic             access_ack,     // access accepted this cycle
  output logic             access_busy,    // access in progress
  output logic             primary_enabled,   // primary controller on
  output logic             secondary_enabled, // secondary controller on
  output logic             cmd_valid,      // one-cycle pulse, command issued
  output logic      [3:0]  cmd_code,       // code of command issued
  output logic             cmd_secondary,  // command targets secondary interface
  output logic             refresh_pulse,  // one-cycle pulse, auto refresh issued
  output logic             sdram_clock_en, // sdram clock running
  output logic      [1:0]  sleep_mode      // power-down action in force, 0 when awake
);

  typedef struct packed {
    scrp_state_type state;
    logic        p_on;
    logic        s_on;
    logic        p_pend;
    logic        s_pend;
    logic [3:0]  p_code;
    logic [3:0]  s_code;
    logic [15:0] rfsh;
    logic [4:0]  apd;
    logic [15:0] rcnt;
    logic        rdue;
    logic [3:0]  rspace;
    logic [9:0]  idle;
    logic [3:0]  tcnt;
    logic        cur_sec;
    logic [31:0] rdata;
    logic        cvalid;
    logic [3:0]  ccode;
    logic        csec;
    logic        rpulse;
    logic        clk_en;
    logic [1:0]  smode;
  } scrp_regs_type;

  scrp_regs_type r;
  scrp_regs_type next_r;

  // idle limit from timer field: 64 shifted left by the code
  function automatic logic [9:0] idle_limit(input logic [1:0] t);
    idle_limit = IDLE_BASE << t;
  endfunction

  logic wr_cmd;
  logic wr_rfsh;
  logic wr_apd;
  logic any_on;
  logic [1:0] mode_sel;

  // address decode of the register port
  always_comb begin
    wr_cmd  = 1'b0;
    wr_rfsh = 1'b0;
    wr_apd  = 1'b0;
    if (reg_wr && reg_addr == ADDR_CMD) begin
      wr_cmd = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_RFSH) begin
      wr_rfsh = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_APD) begin
      wr_apd = 1'b1;
    end
  end

  assign any_on   = r.p_on | r.s_on;
  assign mode_sel = r.apd[APD_MODE_LSB +: 2];

  // next-state logic for registers, refresh timer, idle timer and sequencer
  always_comb begin
    next_r        = r;
    next_r.cvalid = 1'b0;
    next_r.rpulse = 1'b0;
    // register writes
    if (wr_cmd) begin
      if (reg_wdata[P_ON_BIT]) next_r.p_on = 1'b1;
      if (reg_wdata[P_OFF_BIT]) next_r.p_on = 1'b0;
      if (reg_wdata[S_ON_BIT]) next_r.s_on = 1'b1;
      if (reg_wdata[S_OFF_BIT]) next_r.s_on = 1'b0;
      if (!r.p_pend) next_r.p_code = reg_wdata[P_CODE_LSB +: 4];
      if (!r.s_pend) next_r.s_code = reg_wdata[S_CODE_LSB +: 4];
      if (reg_wdata[P_LAUNCH_BIT]) next_r.p_pend = 1'b1;
      if (reg_wdata[S_LAUNCH_BIT]) next_r.s_pend = 1'b1;
    end
    if (wr_rfsh) next_r.rfsh = reg_wdata[15:0];
    if (wr_apd) next_r.apd = reg_wdata[4:0];
    // read data, one cycle after the strobe
    next_r.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == ADDR_CMD) begin
        next_r.rdata[P_STAT_BIT]           = r.p_on;
        next_r.rdata[P_LAUNCH_BIT]         = r.p_pend;
        next_r.rdata[P_CODE_LSB +: 4]      = r.p_code;
        next_r.rdata[S_STAT_BIT]           = r.s_on;
        next_r.rdata[S_LAUNCH_BIT]         = r.s_pend;
        next_r.rdata[S_CODE_LSB +: 4]      = r.s_code;
      end else if (reg_addr == ADDR_RFSH) begin
        next_r.rdata[15:0] = r.rfsh;
      end else if (reg_addr == ADDR_APD) begin
        next_r.rdata[4:0] = r.apd;
      end
    end
    if (r.rspace != 4'h0) next_r.rspace = r.rspace - 4'h1;
    if (r.tcnt != 4'h0) next_r.tcnt = r.tcnt - 4'h1;
    // sequencer
    case (r.state)
      ST_IDLE: begin
        if (r.idle != 10'h3ff) next_r.idle = r.idle + 10'h001;
        if (access_req && any_on) begin
          next_r.state = ST_ACCESS;
          next_r.tcnt  = ACC_TIME;
          next_r.idle  = 10'h000;
        end else if (r.rdue && r.rspace == 4'h0) begin
          next_r.state  = ST_REFRESH;
          next_r.rdue   = 1'b0;
          next_r.rpulse = 1'b1;
          next_r.rspace = RFC_SPACING;
          next_r.tcnt   = RFC_SPACING - 4'h1; // ST_REFRESH lasts 9 clocks, one less than the spacing
        end else if (r.p_pend || r.s_pend) begin
          next_r.state   = ST_CMD;
          next_r.cur_sec = !r.p_pend;
          next_r.cvalid  = 1'b1;
          next_r.ccode   = r.p_pend ? r.p_code : r.s_code;
          next_r.csec    = !r.p_pend;
          next_r.tcnt    = CMD_TIME;
        end else if (mode_sel != APD_OFF && any_on && r.idle >= idle_limit(r.apd[APD_TIMER_LSB +: 2])) begin
          next_r.state  = ST_SLEEP;
          next_r.smode  = mode_sel;
          next_r.clk_en = !r.apd[APD_GATE_BIT];
        end
      end
      ST_ACCESS: begin
        // a refresh coming due here stays latched in rdue
        if (r.tcnt == 4'h0) next_r.state = ST_IDLE;
      end
      ST_REFRESH: begin
        if (r.tcnt == 4'h0) next_r.state = ST_IDLE;
      end
      ST_CMD: begin
        if (r.tcnt == 4'h0) begin
          next_r.state = ST_IDLE;
          // a launch written in the completion cycle re-arms pending
          if (r.cur_sec && !(wr_cmd && reg_wdata[S_LAUNCH_BIT])) next_r.s_pend = 1'b0;
          if (!r.cur_sec && !(wr_cmd && reg_wdata[P_LAUNCH_BIT])) next_r.p_pend = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (access_req || r.rdue || r.p_pend || r.s_pend || !any_on) begin
          next_r.state  = ST_WAKE;
          next_r.clk_en = 1'b1;
          next_r.smode  = 2'h0;
          next_r.tcnt   = CMD_TIME;
        end
      end
      default: begin
        if (r.tcnt == 4'h0) begin
          next_r.state = ST_IDLE;
          next_r.idle  = 10'h000;
        end
      end
    endcase
    // periodic refresh request, latched until served; after the sequencer
    // so that a request falling due in the serve cycle is not lost
    if (r.rfsh == 16'h0000 || !any_on) begin
      next_r.rcnt = 16'h0000;
    end else if (r.rcnt >= r.rfsh - 16'h0001) begin
      next_r.rcnt = 16'h0000;
      next_r.rdue = 1'b1;
    end else begin
      next_r.rcnt = r.rcnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r        <= '0;
      r.state  <= ST_IDLE;
      r.rfsh   <= RFSH_RESET;
      r.apd    <= APD_RESET;
      r.clk_en <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs
  assign reg_rdata         = r.rdata;
  assign access_ack        = (r.state == ST_IDLE) && access_req && any_on;
  assign access_busy       = (r.state == ST_ACCESS);
  assign primary_enabled   = r.p_on;
  assign secondary_enabled = r.s_on;
  assign cmd_valid         = r.cvalid;
  assign cmd_code          = r.ccode;
  assign cmd_secondary     = r.csec;
  assign refresh_pulse     = r.rpulse;
  assign sdram_clock_en    = r.clk_en;
  assign sleep_mode        = r.smode;

  // register and enable checks
  a_primary_on: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_cmd && reg_wdata[P_ON_BIT] && !reg_wdata[P_OFF_BIT] |=> primary_enabled)
    else $error("primary enable write ignored");
  a_primary_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_cmd && reg_wdata[P_OFF_BIT] |=> !primary_enabled)
    else $error("primary disable write ignored");
  a_secondary_on: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_cmd && reg_wdata[S_ON_BIT] && !reg_wdata[S_OFF_BIT] |=> secondary_enabled)
    else $error("secondary enable write ignored");
  a_secondary_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_cmd && reg_wdata[S_OFF_BIT] |=> !secondary_enabled)
    else $error("secondary disable write ignored");
  a_status_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_CMD |=> reg_rdata[P_STAT_BIT] == $past(primary_enabled))
    else $error("primary status read wrong");
  a_secondary_status: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_addr == ADDR_CMD |=> reg_rdata[S_STAT_BIT] == $past(secondary_enabled))
    else $error("secondary status read wrong");
  // one-shot command checks
  a_launch_pend: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_cmd && reg_wdata[P_LAUNCH_BIT] |=> r.p_pend)
    else $error("launch not pending");
  a_secondary_pend: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_cmd && reg_wdata[S_LAUNCH_BIT] |=> r.s_pend)
    else $error("secondary launch not pending");
  a_pend_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    r.state == ST_CMD && r.tcnt == 4'h0 && !r.cur_sec && !(wr_cmd && reg_wdata[P_LAUNCH_BIT]) |=> !r.p_pend)
    else $error("pending not cleared at completion");
  a_secondary_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    r.state == ST_CMD && r.tcnt == 4'h0 && r.cur_sec && !(wr_cmd && reg_wdata[S_LAUNCH_BIT]) |=> !r.s_pend)
    else $error("secondary pending not cleared at completion");
  a_code_held: assert property (@(posedge sys_clk) disable iff (!nrst)
    r.p_pend |=> $stable(r.p_code))
    else $error("command code changed while pending");
  a_cmd_issue: assert property (@(posedge sys_clk) disable iff (!nrst)
    r.state == ST_IDLE && r.p_pend && !access_ack && !r.rdue
    |=> cmd_valid && cmd_code == $past(r.p_code) && !cmd_secondary)
    else $error("pending primary command not issued");
  // refresh checks
  a_no_refresh: assert property (@(posedge sys_clk) disable iff (!nrst)
    r.rfsh == 16'h0000 && !r.rdue |=> !refresh_pulse)
    else $error("refresh with zero period");
  a_rcnt_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    r.rfsh == 16'h0000 |=> r.rcnt == 16'h0000)
    else $error("refresh timer runs with zero period");
  a_refresh_spacing: assert property (@(posedge sys_clk) disable iff (!nrst)
    refresh_pulse |=> !refresh_pulse [*8] ##1 !refresh_pulse)
    else $error("refreshes too close");
  a_no_refresh_in_access: assert property (@(posedge sys_clk) disable iff (!nrst)
    access_busy |-> !refresh_pulse)
    else $error("refresh during access");
  a_refresh_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
    access_busy && r.rdue |=> r.rdue)
    else $error("due refresh dropped during access");
  // power-down checks
  a_gate_clock: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sdram_clock_en |-> r.apd[APD_GATE_BIT] && r.state == ST_SLEEP)
    else $error("clock gated without gate bit");
  a_gate_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(sleep_mode != 2'h0) |-> sdram_clock_en == !$past(r.apd[APD_GATE_BIT]))
    else $error("clock gating does not follow gate bit");
  a_wake_access: assert property (@(posedge sys_clk) disable iff (!nrst)
    r.state == ST_SLEEP && access_req |=> sdram_clock_en && sleep_mode == 2'h0)
    else $error("access did not wake device");
  a_idle_limit: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(sleep_mode != 2'h0) |-> $past(r.idle) >= idle_limit($past(r.apd[1:0])))
    else $error("sleep before idle limit");
  // coverage of the main scenarios
  c_command: cover property (@(posedge sys_clk) cmd_valid);
  c_refresh: cover property (@(posedge sys_clk) refresh_pulse);
  c_sleep_wake: cover property (@(posedge sys_clk) r.state == ST_SLEEP ##1 r.state == ST_WAKE);
  c_gated: cover property (@(posedge sys_clk) !sdram_clock_en);

endmodule

/* File: test/scrp_sdram_model.sv */
// far-side sdram model: logs issued commands and refresh spacing
`timescale 1ns/1ps
module scrp_sdram_model (
  input  wire logic        sys_clk,       // clock
  input  wire logic        nrst,          // reset, active low
  input  wire logic        cmd_valid,     // command strobe
  input  wire logic [3:0]  cmd_code,      // command code
  input  wire logic        cmd_secondary, // secondary target
  input  wire logic        refresh_pulse, // auto refresh strobe
  output logic      [15:0] cmd_cnt,       // commands seen
  output logic      [3:0]  last_code,     // last code seen
  output logic             last_sec,      // last target seen
  output logic      [15:0] rfsh_cnt,      // refreshes seen
  output logic      [15:0] last_gap       // cycles between last two refreshes
);
  logic [15:0] gap;
  // latch each command and time each refresh
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {cmd_cnt, last_code, last_sec, rfsh_cnt, last_gap, gap} <= '0;
    end else begin
      gap <= refresh_pulse ? 16'h0001 : gap + 16'h0001;
      if (cmd_valid) begin
        cmd_cnt   <= cmd_cnt + 16'h0001;
        last_code <= cmd_code;
        last_sec  <= cmd_secondary;
      end
      if (refresh_pulse) begin
        rfsh_cnt <= rfsh_cnt + 16'h0001;
        last_gap <= gap;
      end
    end
  end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the sdram command, refresh and power-down block
`timescale 1ns/1ps
module testbench
  import scrp_pkg::*;
;
  logic        sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, access_req = 0;
  logic [3:0]  reg_addr = 4'h0, last_code;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, q;
  logic        access_ack, access_busy, primary_enabled, secondary_enabled, cmd_valid, cmd_secondary;
  logic        refresh_pulse, sdram_clock_en, last_sec;
  logic [3:0]  cmd_code;
  logic [1:0]  sleep_mode, md, tm;
  logic [15:0] cmd_cnt, rfsh_cnt, last_gap, c0;
  logic [31:0] ens [4] = '{32'h02000000, 32'h00000200, 32'h01000000, 32'h00000300};
  logic [1:0]  exps [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  int          error_cnt = 0, checked = 0, cyc = 0, ovl = 0, n, i, k;
  scrp_ctrl i_dut (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .access_req,
    .access_ack, .access_busy, .primary_enabled, .secondary_enabled, .cmd_valid, .cmd_code,
    .cmd_secondary, .refresh_pulse, .sdram_clock_en, .sleep_mode);
  scrp_sdram_model i_mem (.sys_clk, .nrst, .cmd_valid, .cmd_code, .cmd_secondary, .refresh_pulse,
    .cmd_cnt, .last_code, .last_sec, .rfsh_cnt, .last_gap);
  // clock, cycle ceiling and refresh-during-access watch
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (refresh_pulse === 1'b1 && access_busy === 1'b1) ovl++;
    if (cyc == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  // expected idle limit and launch word
  function automatic logic [9:0] idle_lim(input logic [1:0] t);
    return IDLE_BASE << t;
  endfunction
  function automatic logic [31:0] launch(input logic s, input logic [3:0] c);
    return s ? (32'h10 | c) : (32'h00100000 | (32'(c) << 16));
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // one access: hold request until accepted, then count busy cycles
  task automatic access();
    int b;
    @(posedge sys_clk);
    access_req <= 1'b1;
    for (b = 0; b < 40 && access_ack !== 1'b1; b++) @(negedge sys_clk);
    chk(access_ack, 1, "access not accepted");
    @(posedge sys_clk);
    access_req <= 1'b0;
    for (b = 0; b < 20; b++) @(negedge sys_clk) if (access_busy !== 1'b1) break;
    chk(b, 32'(ACC_TIME) + 1, "access length");
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h169339d3));
    wait_cyc(3);
    nrst <= 1'b1;
    foreach (ens[j]) begin
      rd(4'h4 * j[3:0]);
      chk(q, 0, "reset value or unmapped read");
    end
    // enable and disable both controllers, disable wins on a secondary tie
    foreach (ens[j]) begin
      wr(ADDR_CMD, ens[j]);
      rd(ADDR_CMD);
      chk({q[P_STAT_BIT], q[S_STAT_BIT]}, exps[j], "status bits");
    end
    chk({primary_enabled, secondary_enabled}, 2'b00, "enable ports");
    // codes 0 to 7 on both interfaces, pending then done
    for (k = 0; k < 16; k++) begin
      c0 = cmd_cnt;
      wr(ADDR_CMD, launch(k[0], k[3:1]));
      rd(ADDR_CMD);
      chk(q[k[0] ? S_LAUNCH_BIT : P_LAUNCH_BIT], 1, "not pending");
      wait_cyc(12);
      chk({cmd_cnt, last_code, last_sec}, {c0 + 16'h1, 1'b0, k[3:1], k[0]}, "issued command");
      rd(ADDR_CMD);
      chk(q[P_LAUNCH_BIT] | q[S_LAUNCH_BIT], 0, "still pending");
    end
    c0 = cmd_cnt;
    wr(ADDR_CMD, 32'h00050005);
    wait_cyc(12);
    chk(cmd_cnt, c0, "launch without execute bit");
    rd(ADDR_CMD);
    chk({q[P_CODE_LSB +: 4], q[S_CODE_LSB +: 4]}, 8'h55, "code read-back");
    // refresh period random, with accesses in between
    wr(ADDR_CMD, 32'h02000000);
    n = 12 + ($urandom % 32);
    wr(ADDR_RFSH, n);
    wait_cyc(3 * n);
    chk(last_gap, n, "refresh period");
    repeat (3) access();
    wait_cyc(4 * n);
    chk(last_gap, n, "refresh period after access");
    chk(ovl, 0, "refresh during access");
    wr(ADDR_RFSH, 5);
    wait_cyc(60);
    chk(last_gap, 10, "refresh spacing");
    wr(ADDR_RFSH, 0);
    wait_cyc(12);
    c0 = rfsh_cnt;
    wait_cyc(200);
    chk(rfsh_cnt, c0, "refresh while disabled");
    // power-down modes, timers and clock gating
    for (md = 0; md < 3; md++) begin
      tm = $urandom % 2;
      wr(ADDR_APD, {md[0], md + 2'd1, tm});
      access();
      wait_cyc(idle_lim(tm) - 8);
      chk(sleep_mode, 0, "early sleep");
      for (i = 0; i < 20 && sleep_mode === 2'b00; i++) @(negedge sys_clk);
      chk({sleep_mode, sdram_clock_en}, {md + 2'd1, ~md[0]}, "sleep entry");
      access();
      chk({sleep_mode, sdram_clock_en}, 3'b001, "awake after access");
    end
    wr(ADDR_APD, 5'h10);
    wait_cyc(100);
    chk({sleep_mode, sdram_clock_en}, 3'b001, "mode off sleeps");
    finish_test();
  end
endmodule
